// file: inc/spl_defines.svh
// register offsets, fields, reset values and timing for the setpoint path
`ifndef SPL_DEFINES_SVH
`define SPL_DEFINES_SVH
`define OFS_CTRL 8'h00
`define OFS_LOCAL_SP 8'h04
`define OFS_UPPER 8'h08
`define OFS_LOWER 8'h0c
`define OFS_RANGE_HI 8'h10
`define OFS_RANGE_LO 8'h14
`define OFS_ADJ_RAMP 8'h18
`define OFS_STATUS 8'h1c
`define OFS_RAMP_MON 8'h20
`define OFS_BANK_RAMP 8'h40
`define OFS_MV_HI 8'h60
`define OFS_MV_LO 8'h80
`define REGION_MASK 8'he0
`define F_RUN 0
`define F_REMOTE 1
`define F_ALM_SEL 2
`define F_AT_REQ 3
`define F_LIM_RST 4
`define F_RANGE_CHG 5
`define F_UNIT 9:8
`define F_BANK 14:12
`define F_PID 18:16
`define ST_RAMPING 0
`define ST_AT_RUN 1
`define ST_RAMP_EN 2
`define ST_ERROR 3
`define RST_UPPER 16'h7fff
`define RST_LOWER 16'h8000
`define RAMP_OFF 16'h0000
`define RST_MV_HI 16'h03e8
`define RST_MV_LO 16'h0000
`define CLK_HZ 200000000
`define TICK_S 1
`define MIN_SECS 60
`define HOUR_MINS 60
`endif

// file: inc/spl_pkg.sv
// types shared by the setpoint path
package spl_pkg;
    typedef logic signed [15:0] sp_t;
    typedef enum logic [1:0] {UNIT_SEC, UNIT_MIN, UNIT_HOUR} time_unit_t;
endpackage

// file: inc/rate_if.sv
// enable in and divided pulse out of one timebase stage
interface rate_if;
    logic en;
    logic pulse;
    modport src(input en, output pulse);
    modport snk(output en, input pulse);
endinterface

// file: hdl/pulse_div.sv
// divides a one-cycle enable by a fixed count
module pulse_div #(
    parameter int unsigned COUNT = 60
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // enable in, pulse out
    rate_if.src rate
);
    localparam int W = $clog2(COUNT + 1);
    logic [W-1:0] cnt_r;

    // count enables, pulse on the last one
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_r <= '0;
            rate.pulse <= 1'b0;
        end else begin
            rate.pulse <= 1'b0;
            if (rate.en) begin
                if (cnt_r == W'(COUNT - 1)) begin
                    cnt_r <= '0;
                    rate.pulse <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 1'b1;
                end
            end
        end
    end
endmodule

// file: hdl/setpoint_limit_ramp.sv
// setpoint limiter, ramp, alarm setpoint and mv clamp behind apb
//
// Behaviour
// - setpoint held inside upper and lower limit
// - limiter reset pulls setpoint to violated bound
// - range change reloads limits from input range
// - ramping controls to rate limited setpoint
// - rate is amount per selected time unit
// - amount zero means off, changes apply immediately
// - eight bank amounts, active bank used
// - ramp setpoint readable as monitor
// - adjustment write lands in active bank
// - local to remote switch also ramps
// - run start ramps from process value
// - auto-tuning waits for ramp end
// - stop or error disables ramping
// - alarm setpoint ramp or target by select
// - mv clamped by active pid set limits
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`include "spl_defines.svh"

module setpoint_limit_ramp
    import spl_pkg::*;
#(
    parameter int unsigned SEC_CYCLES = `CLK_HZ * `TICK_S,
    parameter int unsigned NBANK = 8,
    parameter int unsigned NPID = 8
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // process side
    input wire sp_t pv_in,
    input wire sp_t remote_sp_in,
    input wire logic error_in,
    input wire sp_t mv_in,
    // conditioned results
    output sp_t control_sp_out,
    output sp_t alarm_sp_out,
    output sp_t mv_out,
    output logic ramping_out,
    output logic at_run_out
);
    localparam int BW = $clog2(NBANK);
    localparam int PW = $clog2(NPID);

    // =========================================================
    // state
    logic run_r, run_prev_r, remote_r, alm_sel_r, at_req_r, reclamp_r;
    time_unit_t unit_r;
    logic [BW-1:0] bank_r;
    logic [PW-1:0] pid_r;
    sp_t local_sp_r, upper_r, lower_r, range_hi_r, range_lo_r;
    logic [15:0] ramp_amt_r [NBANK];
    sp_t mv_hi_r [NPID];
    sp_t mv_lo_r [NPID];
    sp_t ramp_sp_r, alarm_sp_r, mv_r;
    logic ramping_r, at_run_r;
    logic [31:0] prdata_r;

    function automatic sp_t clamp(sp_t v, sp_t lo, sp_t hi);
        if (v > hi) begin
            return hi;
        end else if (v < lo) begin
            return lo;
        end
        return v;
    endfunction

    // =========================================================
    // apb decode
    logic setup, wr, aligned, single_hit, hit;
    logic reg_bank, reg_mv_hi, reg_mv_lo;
    logic wr_ctrl, wr_local, wr_upper, wr_lower;
    logic [BW-1:0] bidx;
    logic [PW-1:0] pidx;
    assign setup = psel_in & ~penable_in;
    assign wr = psel_in & penable_in & pwrite_in & hit;
    assign aligned = (paddr_in[1:0] == 2'h0);
    assign reg_bank = ((paddr_in & `REGION_MASK) == `OFS_BANK_RAMP);
    assign reg_mv_hi = ((paddr_in & `REGION_MASK) == `OFS_MV_HI);
    assign reg_mv_lo = ((paddr_in & `REGION_MASK) == `OFS_MV_LO);
    assign bidx = BW'(paddr_in[4:2]);
    assign pidx = PW'(paddr_in[4:2]);

    // single registers
    always_comb begin
        case (paddr_in)
            `OFS_CTRL, `OFS_LOCAL_SP, `OFS_UPPER, `OFS_LOWER,
            `OFS_RANGE_HI, `OFS_RANGE_LO, `OFS_ADJ_RAMP,
            `OFS_STATUS, `OFS_RAMP_MON: single_hit = 1'b1;
            default: single_hit = 1'b0;
        endcase
    end

    assign hit = aligned & (single_hit | reg_bank | reg_mv_hi | reg_mv_lo);
    assign wr_ctrl = wr & (paddr_in == `OFS_CTRL);
    assign wr_local = wr & (paddr_in == `OFS_LOCAL_SP);
    assign wr_upper = wr & (paddr_in == `OFS_UPPER);
    assign wr_lower = wr & (paddr_in == `OFS_LOWER);
    assign pready_out = 1'b1; // zero wait states
    assign pslverr_out = psel_in & penable_in & ~hit;

    // =========================================================
    // control register and limits
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            run_r <= 1'b0;
            remote_r <= 1'b0;
            alm_sel_r <= 1'b0;
            at_req_r <= 1'b0;
            unit_r <= UNIT_SEC;
            bank_r <= '0;
            pid_r <= '0;
            upper_r <= `RST_UPPER;
            lower_r <= `RST_LOWER;
            range_hi_r <= `RST_UPPER;
            range_lo_r <= `RST_LOWER;
            reclamp_r <= 1'b0;
        end else begin
            reclamp_r <= wr_upper | wr_lower
                | (wr_ctrl & (pwdata_in[`F_LIM_RST] | pwdata_in[`F_RANGE_CHG]));
            if (wr_ctrl) begin
                run_r <= pwdata_in[`F_RUN];
                remote_r <= pwdata_in[`F_REMOTE];
                alm_sel_r <= pwdata_in[`F_ALM_SEL];
                at_req_r <= pwdata_in[`F_AT_REQ];
                unit_r <= time_unit_t'(pwdata_in[`F_UNIT]);
                bank_r <= BW'(pwdata_in[`F_BANK]);
                pid_r <= PW'(pwdata_in[`F_PID]);
            end
            if (wr_ctrl && pwdata_in[`F_RANGE_CHG]) begin
                upper_r <= range_hi_r;
                lower_r <= range_lo_r;
            end else begin
                if (wr_upper) begin
                    upper_r <= pwdata_in[15:0];
                end
                if (wr_lower) begin
                    lower_r <= pwdata_in[15:0];
                end
            end
            if (wr & (paddr_in == `OFS_RANGE_HI)) begin
                range_hi_r <= pwdata_in[15:0];
            end
            if (wr & (paddr_in == `OFS_RANGE_LO)) begin
                range_lo_r <= pwdata_in[15:0];
            end
        end
    end

    // local setpoint, clamped on write and after any limiter reset
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            local_sp_r <= '0;
        end else if (wr_local) begin
            local_sp_r <= clamp(pwdata_in[15:0], lower_r, upper_r);
        end else if (reclamp_r) begin
            local_sp_r <= clamp(local_sp_r, lower_r, upper_r);
        end
    end

    // per-bank ramp amounts, zero reads as off
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < NBANK; i++) begin
                ramp_amt_r[i] <= `RAMP_OFF;
            end
        end else if (wr & reg_bank) begin
            ramp_amt_r[bidx] <= pwdata_in[15:0];
        end else if (wr & (paddr_in == `OFS_ADJ_RAMP)) begin
            ramp_amt_r[bank_r] <= pwdata_in[15:0];
        end
    end

    // per-set mv limits
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < NPID; i++) begin
                mv_hi_r[i] <= `RST_MV_HI;
                mv_lo_r[i] <= `RST_MV_LO;
            end
        end else begin
            if (wr & reg_mv_hi) begin
                mv_hi_r[pidx] <= pwdata_in[15:0];
            end
            if (wr & reg_mv_lo) begin
                mv_lo_r[pidx] <= pwdata_in[15:0];
            end
        end
    end

    // =========================================================
    // timebase: seconds, minutes, hours
    rate_if sec_if ();
    rate_if min_if ();
    rate_if hour_if ();
    assign sec_if.en = 1'b1;
    assign min_if.en = sec_if.pulse;
    assign hour_if.en = min_if.pulse;

    pulse_div #(.COUNT(SEC_CYCLES)) u_sec (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .rate(sec_if.src)
    );
    pulse_div #(.COUNT(`MIN_SECS)) u_min (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .rate(min_if.src)
    );
    pulse_div #(.COUNT(`HOUR_MINS)) u_hour (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .rate(hour_if.src)
    );

    // =========================================================
    // ramp engine
    logic unit_tick, ramp_en, run_rise, ramping;
    logic [15:0] amt;
    sp_t tgt, step_val, mv_hi_sel, mv_lo_sel;
    logic signed [16:0] diff, amt17, up_v, dn_v;

    // select the period pulse of the chosen unit
    always_comb begin
        case (unit_r)
            UNIT_SEC: unit_tick = sec_if.pulse;
            UNIT_MIN: unit_tick = min_if.pulse;
            UNIT_HOUR: unit_tick = hour_if.pulse;
            default: unit_tick = 1'b0;
        endcase
    end

    assign tgt = clamp(remote_r ? remote_sp_in : local_sp_r, lower_r, upper_r);
    assign amt = ramp_amt_r[bank_r];
    assign ramp_en = (amt != `RAMP_OFF) & run_r & ~error_in;
    assign run_rise = run_r & ~run_prev_r;
    assign ramping = ramp_en & (ramp_sp_r != tgt);

    // one bounded step toward the target
    always_comb begin
        amt17 = signed'({1'b0, amt});
        diff = 17'(tgt) - 17'(ramp_sp_r);
        up_v = 17'(ramp_sp_r) + amt17;
        dn_v = 17'(ramp_sp_r) - amt17;
        if (diff > amt17) begin
            step_val = up_v[15:0];
        end else if (diff < -amt17) begin
            step_val = dn_v[15:0];
        end else begin
            step_val = tgt;
        end
    end

    // run edge detect
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            run_prev_r <= 1'b0;
        end else begin
            run_prev_r <= run_r;
        end
    end

    // ramping setpoint; a source switch keeps it and ramps on
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ramp_sp_r <= '0;
        end else if (!ramp_en) begin
            ramp_sp_r <= tgt;
        end else if (run_rise) begin
            ramp_sp_r <= pv_in;
        end else if (unit_tick) begin
            ramp_sp_r <= step_val;
        end
    end

    assign control_sp_out = ramp_sp_r;

    // =========================================================
    // alarm setpoint, mv clamp, tuning hold-off
    assign mv_hi_sel = mv_hi_r[pid_r];
    assign mv_lo_sel = mv_lo_r[pid_r];

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            alarm_sp_r <= '0;
            mv_r <= '0;
            ramping_r <= 1'b0;
            at_run_r <= 1'b0;
        end else begin
            alarm_sp_r <= alm_sel_r ? tgt : ramp_sp_r;
            mv_r <= clamp(mv_in, mv_lo_sel, mv_hi_sel);
            ramping_r <= ramping;
            at_run_r <= at_req_r & (at_run_r | ~ramping);
        end
    end

    assign alarm_sp_out = alarm_sp_r;
    assign mv_out = mv_r;
    assign ramping_out = ramping_r;
    assign at_run_out = at_run_r;

    // =========================================================
    // apb read data, captured in the setup cycle
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            prdata_r <= '0;
        end else if (setup) begin
            prdata_r <= '0;
            case (paddr_in)
                `OFS_CTRL: begin
                    prdata_r[`F_RUN] <= run_r;
                    prdata_r[`F_REMOTE] <= remote_r;
                    prdata_r[`F_ALM_SEL] <= alm_sel_r;
                    prdata_r[`F_AT_REQ] <= at_req_r;
                    prdata_r[`F_UNIT] <= unit_r;
                    prdata_r[`F_BANK] <= 3'(bank_r);
                    prdata_r[`F_PID] <= 3'(pid_r);
                end
                `OFS_LOCAL_SP: prdata_r[15:0] <= local_sp_r;
                `OFS_UPPER: prdata_r[15:0] <= upper_r;
                `OFS_LOWER: prdata_r[15:0] <= lower_r;
                `OFS_RANGE_HI: prdata_r[15:0] <= range_hi_r;
                `OFS_RANGE_LO: prdata_r[15:0] <= range_lo_r;
                `OFS_ADJ_RAMP: prdata_r[15:0] <= amt;
                `OFS_STATUS: begin
                    prdata_r[`ST_RAMPING] <= ramping;
                    prdata_r[`ST_AT_RUN] <= at_run_r;
                    prdata_r[`ST_RAMP_EN] <= ramp_en;
                    prdata_r[`ST_ERROR] <= error_in;
                end
                `OFS_RAMP_MON: prdata_r[15:0] <= ramp_sp_r;
                default: begin
                    if (reg_bank) begin
                        prdata_r[15:0] <= ramp_amt_r[bidx];
                    end else if (reg_mv_hi) begin
                        prdata_r[15:0] <= mv_hi_r[pidx];
                    end else if (reg_mv_lo) begin
                        prdata_r[15:0] <= mv_lo_r[pidx];
                    end
                end
            endcase
        end
    end

    assign prdata_out = prdata_r;

    // =========================================================
    // checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    AST_SP_WITHIN_LIMITS: assert property (
        !ramp_en && lower_r <= upper_r && $stable(lower_r) && $stable(upper_r)
        |=> ramp_sp_r >= $past(lower_r) && ramp_sp_r <= $past(upper_r))
        else $error("setpoint outside limits");
    AST_LIMIT_RESET_CLAMP: assert property (
        reclamp_r && !wr_local && lower_r <= upper_r
        |=> local_sp_r >= $past(lower_r) && local_sp_r <= $past(upper_r))
        else $error("limiter reset left setpoint outside");
    AST_RANGE_RELOAD: assert property (
        wr_ctrl && pwdata_in[`F_RANGE_CHG]
        |=> upper_r == $past(range_hi_r) && lower_r == $past(range_lo_r))
        else $error("limits not reloaded from range");
    AST_HOLD_BETWEEN_TICKS: assert property (
        ramp_en && !unit_tick && !run_rise |=> ramp_sp_r == $past(ramp_sp_r))
        else $error("ramp moved without a period tick");
    AST_NO_OVERSHOOT: assert property (
        ramp_en && unit_tick && !run_rise && ramp_sp_r <= tgt
        |=> ramp_sp_r <= $past(tgt) && ramp_sp_r >= $past(ramp_sp_r))
        else $error("ramp overshot target");
    AST_OFF_FOLLOWS: assert property (
        !run_r || error_in || amt == `RAMP_OFF ##1 1'b1 |-> ramp_sp_r == $past(tgt))
        else $error("disabled ramp did not follow target");
    AST_ADJ_TO_BANK: assert property (
        wr && paddr_in == `OFS_ADJ_RAMP
        |=> ramp_amt_r[$past(bank_r)] == $past(pwdata_in[15:0]))
        else $error("adjustment ramp not in active bank");
    AST_START_FROM_PV: assert property (
        run_rise && ramp_en |=> ramp_sp_r == $past(pv_in))
        else $error("ramp did not start from process value");
    AST_AT_WAITS: assert property (
        $rose(at_run_r) |-> !$past(ramping))
        else $error("tuning started during ramp");
    AST_ALARM_TARGET: assert property (
        alm_sel_r |=> alarm_sp_r == $past(tgt))
        else $error("alarm setpoint not the target");
    AST_MV_CLAMP: assert property (
        mv_lo_sel <= mv_hi_sel ##1 1'b1
        |-> mv_r <= $past(mv_hi_sel) && mv_r >= $past(mv_lo_sel))
        else $error("mv outside set limits");
    AST_MONITOR_READ: assert property (
        setup && paddr_in == `OFS_RAMP_MON |=> prdata_r[15:0] == $past(ramp_sp_r))
        else $error("monitor read wrong");

    COV_RAMP_STEP: cover property (ramp_en && unit_tick && ramping);
    COV_REMOTE_SWITCH: cover property (ramp_en && $rose(remote_r));
    COV_AT_AFTER_RAMP: cover property ($fell(ramping_r) ##[0:20] $rose(at_run_r));
endmodule

// file: test/pv_loop_model.sv
// process value front end and raw mv source facing the setpoint path
module pv_loop_model
    import spl_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // commands from the bench
    input wire sp_t pv_cmd_in,
    input wire sp_t remote_cmd_in,
    input wire sp_t mv_cmd_in,
    input wire logic err_cmd_in,
    // toward the setpoint path
    output sp_t pv_out,
    output sp_t remote_sp_out,
    output sp_t mv_raw_out,
    output logic error_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // measurement front end registers every value once per cycle
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pv_out <= 16'h0000;
            remote_sp_out <= 16'h0000;
            mv_raw_out <= 16'h0000;
            error_out <= 1'b0;
        end else begin
            pv_out <= pv_cmd_in;
            remote_sp_out <= remote_cmd_in;
            mv_raw_out <= mv_cmd_in;
            error_out <= err_cmd_in;
        end
    end
endmodule

// file: test/setpoint_limit_ramp_bench.sv
// self-checking bench for the setpoint path
`include "spl_defines.svh"
module setpoint_limit_ramp_bench
    import spl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // signals
    localparam int SEC = 10;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, ctrl;
    logic pready, pslverr, ramping, at_run, err, err_cmd = 1'b0;
    sp_t pv_cmd = 16'h0000, remote_cmd = 16'h0000, mv_cmd = 16'h0000;
    sp_t pv, remote_sp, mv_raw, control_sp, alarm_sp, mv_out;
    int error_cnt = 0, num_checks = 0, seed = 32'h2a53add0;
    always #2.5 clk_in = ~clk_in;
    // ==========================================
    // design and partner
    setpoint_limit_ramp #(.SEC_CYCLES(SEC), .NBANK(8), .NPID(8)) dut (
        .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .pv_in(pv), .remote_sp_in(remote_sp),
        .error_in(err), .mv_in(mv_raw), .control_sp_out(control_sp), .alarm_sp_out(alarm_sp),
        .mv_out(mv_out), .ramping_out(ramping), .at_run_out(at_run));
    pv_loop_model partner (
        .clk_in(clk_in), .rst_in(rst_in), .pv_cmd_in(pv_cmd), .remote_cmd_in(remote_cmd),
        .mv_cmd_in(mv_cmd), .err_cmd_in(err_cmd), .pv_out(pv), .remote_sp_out(remote_sp),
        .mv_raw_out(mv_raw), .error_out(err));
    // ==========================================
    // compare, bus and expectation helpers
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_sp(input sp_t got, input sp_t exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic e);
        int n;
        n = 0;
        @(posedge clk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) error_cnt++;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h00000000, r, e);
        chk_word(r, exp);
    endtask
    function automatic logic [31:0] w16(input sp_t v);
        return {16'h0000, v};
    endfunction
    function automatic sp_t clamp(input sp_t v, input sp_t lo, input sp_t hi);
        if (v > hi) return hi;
        if (v < lo) return lo;
        return v;
    endfunction
    function automatic logic step_ok(input sp_t p, input sp_t c, input sp_t t, input int a);
        if (p < t) return (c > p) && (c <= t) && (c - p <= a);
        return (c < p) && (c >= t) && (p - c <= a);
    endfunction
    // follows one ramp, checking step size, spacing, alarm setpoint and tuning hold-off
    task automatic ramp_check(input sp_t from, input sp_t tgt, input int amt, input int per,
                              input logic sel);
        sp_t prev, last;
        int gap, steps, lim;
        gap = 0;
        steps = 0;
        lim = ((tgt > from ? tgt - from : from - tgt) / amt + 2) * per + 20;
        repeat (3) @(negedge clk_in);
        prev = control_sp;
        last = prev;
        chk_word(32'((prev >= from ? prev - from : from - prev) <= amt), 32'h1);
        for (int n = 0; n < lim && control_sp !== tgt; n++) begin
            @(negedge clk_in);
            gap++;
            if (control_sp !== prev) begin
                chk_word(32'(step_ok(prev, control_sp, tgt, amt)), 32'h1);
                if (steps > 0) chk_word(32'(gap >= per), 32'h1);
                steps++;
                gap = 0;
                prev = control_sp;
            end
            if (sel) chk_sp(alarm_sp, tgt);
            else chk_sp(alarm_sp, last);
            chk_word(32'(at_run & ramping), 32'h0);
            last = control_sp;
        end
        chk_sp(control_sp, tgt);
        repeat (2) @(negedge clk_in);
        chk_word(32'(ramping), 32'h0);
        rd_chk(`OFS_RAMP_MON, w16(tgt));
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // watchdog cuts a hang short
    initial begin
        #450000;
        error_cnt++;
        print_verdict();
    end
    // ==========================================
    // main sequence
    initial begin
        logic [31:0] r;
        logic [15:0] amt [8];
        logic e;
        sp_t lo, hi, v;
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        // reset values, refused access
        apb(1'b1, 8'h02, 32'h00000005, r, e);
        chk_word(32'(e), 32'h1);
        rd_chk(`OFS_UPPER, 32'h00007fff);
        rd_chk(`OFS_LOWER, 32'h00008000);
        rd_chk(`OFS_MV_HI, 32'h000003e8);
        for (int b = 0; b < 8; b++) rd_chk(8'(`OFS_BANK_RAMP + 4 * b), 32'h0);
        // clamping with ramp off while running
        ctrl = 32'h00000001;
        wr(`OFS_CTRL, ctrl);
        wr(`OFS_UPPER, 32'h000003e8);
        wr(`OFS_LOWER, 32'h0000ff9c);
        wr(`OFS_LOCAL_SP, 32'h000007d0);
        rd_chk(`OFS_LOCAL_SP, 32'h000003e8);
        repeat (3) @(negedge clk_in);
        chk_sp(control_sp, 16'h03e8);
        wr(`OFS_LOCAL_SP, 32'h0000ff00);
        repeat (3) @(negedge clk_in);
        chk_sp(control_sp, 16'hff9c);
        // limiter reset and range change
        wr(`OFS_LOCAL_SP, 32'h000001f4);
        wr(`OFS_UPPER, 32'h0000012c);
        repeat (3) @(negedge clk_in);
        chk_sp(control_sp, 16'h012c);
        rd_chk(`OFS_LOCAL_SP, 32'h0000012c);
        wr(`OFS_RANGE_HI, 32'h000000c8);
        wr(`OFS_RANGE_LO, 32'h0000ffce);
        wr(`OFS_CTRL, ctrl | 32'h00000020);
        rd_chk(`OFS_UPPER, 32'h000000c8);
        rd_chk(`OFS_LOWER, 32'h0000ffce);
        repeat (3) @(negedge clk_in);
        chk_sp(control_sp, 16'h00c8);
        // per-bank amounts and adjustment path
        for (int b = 0; b < 8; b++) begin
            amt[b] = 16'($unsigned($random(seed)) % 127 + 1);
            wr(8'(`OFS_BANK_RAMP + 4 * b), {16'h0000, amt[b]});
        end
        for (int b = 0; b < 8; b++) begin
            ctrl[14:12] = 3'(b);
            wr(`OFS_CTRL, ctrl);
            rd_chk(`OFS_ADJ_RAMP, {16'h0000, amt[b]});
        end
        ctrl[14:12] = 3'h2;
        ctrl[0] = 1'b0;
        wr(`OFS_CTRL, ctrl);
        wr(`OFS_ADJ_RAMP, 32'h00000007);
        rd_chk(8'(`OFS_BANK_RAMP + 8), 32'h00000007);
        rd_chk(8'(`OFS_BANK_RAMP + 12), {16'h0000, amt[3]});
        // stopped: follows target; run start ramps from process value
        @(posedge clk_in);
        pv_cmd <= 16'h0064;
        wr(`OFS_LOCAL_SP, 32'h0000003c);
        repeat (4) @(negedge clk_in);
        chk_sp(control_sp, 16'h003c);
        ctrl[0] = 1'b1;
        wr(`OFS_CTRL, ctrl);
        ramp_check(16'h0064, 16'h003c, 7, SEC, 1'b0);
        // each time unit; remote switch; tuning hold-off; alarm target select
        for (int p = 0; p < 3; p++) begin
            ctrl[9:8] = 2'(p);
            ctrl[1] = 1'b1;
            ctrl[3] = (p == 1);
            ctrl[2] = (p == 2);
            @(posedge clk_in);
            remote_cmd <= (p == 1) ? 16'h003c : 16'h0049;
            wr(`OFS_CTRL, ctrl);
            ramp_check((p == 1) ? 16'h0049 : 16'h003c, (p == 1) ? 16'h003c : 16'h0049, 7,
                       (p == 0) ? SEC : (p == 1) ? SEC * 60 : SEC * 3600, ctrl[2]);
            if (p == 1) begin
                repeat (3) @(negedge clk_in);
                chk_word(32'(at_run), 32'h1);
            end
        end
        // error disables ramping mid-ramp
        ctrl[9:8] = 2'h0;
        wr(`OFS_CTRL, ctrl);
        @(posedge clk_in);
        remote_cmd <= 16'h00c8;
        repeat (5) @(negedge clk_in);
        chk_word(32'(ramping), 32'h1);
        @(posedge clk_in);
        err_cmd <= 1'b1;
        repeat (4) @(negedge clk_in);
        chk_sp(control_sp, 16'h00c8);
        chk_word(32'(ramping), 32'h0);
        @(posedge clk_in);
        err_cmd <= 1'b0;
        // mv clamp for every pid set, edges first then random
        for (int p = 0; p < 8; p++) begin
            lo = sp_t'($random(seed) % 300);
            hi = lo + sp_t'($unsigned($random(seed)) % 400);
            wr(8'(`OFS_MV_HI + 4 * p), w16(hi));
            wr(8'(`OFS_MV_LO + 4 * p), w16(lo));
            ctrl[18:16] = 3'(p);
            wr(`OFS_CTRL, ctrl);
            for (int k = 0; k < 4; k++) begin
                v = (k == 0) ? hi + 1 : (k == 1) ? lo - 1 : sp_t'($random(seed) % 1000);
                @(posedge clk_in);
                mv_cmd <= v;
                repeat (3) @(negedge clk_in);
                chk_sp(mv_out, clamp(v, lo, hi));
            end
        end
        print_verdict();
    end
endmodule
